// ==== pkg/ext_bus_pkg.sv ====
package ext_bus_pkg;
	localparam int          addr_width      = 20;
	localparam int          data_width      = 8;
	localparam int          io_addr_width   = 16;
	localparam int          refresh_width   = 8;
	localparam int          timer_addr_bit  = 18;
	localparam int          mux_sel_bit     = 3;
	localparam logic [7:0]  pin_mux_offset  = 8'hdf;
	localparam logic [7:0]  mode_ctl_offset = 8'he0;
	localparam logic [7:0]  status_offset   = 8'he1;
	localparam logic [7:0]  port_c_offset   = 8'he2;
	localparam logic [7:0]  pin_mux_reset   = 8'h00;
	localparam logic [7:0]  mode_ctl_reset  = 8'h01;
	localparam int          mode_oce_bit    = 0;
	localparam int          mode_delay_bit  = 1;
	localparam int          mode_edge1_bit  = 2;
	localparam int          mode_edge2_bit  = 3;
	localparam int          mode_dma0_request_in_bit  = 4;
	localparam int          mode_dma1_request_in_bit  = 5;
	localparam int          mode_timer_bit  = 6;
	localparam int          halt_exit_ns    = 128;
	localparam int          clk_period_ns   = 8;
	localparam int          halt_exit_cycles = 16;
	localparam logic [15:0] nmi_vector      = 16'h0066;
	localparam logic [4:0]  wait_cnt_reset  = 5'h00;

	typedef enum logic [5:0] {
		st_idle  = 6'b000001,
		st_t1    = 6'b000010,
		st_t2    = 6'b000100,
		st_tw    = 6'b001000,
		st_t3    = 6'b010000,
		st_grant = 6'b100000
	} bus_state_t;

	typedef enum logic [2:0] {
		cyc_mem  = 3'h0,
		cyc_io   = 3'h1,
		cyc_fetch = 3'h2,
		cyc_ack0 = 3'h3,
		cyc_ackx = 3'h4,
		cyc_dram_refresh_strobe = 3'h5
	} cycle_kind_t;
endpackage : ext_bus_pkg

// ==== design/mpu_external_bus_interface.sv ====
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - 20-bit address reaches 1 Mbyte memory; I/O cycles use low 16 bits.
// - address outputs float in reset, grant, sleep and halt.
// - during grant, address lines are inputs; low 8 decoded for on-chip register reads.
// - address bit 18 may carry timer pulse; address function after reset.
// - 8-bit data bus floats in reset, grant, sleep and halt.
// - primary interrupt acknowledge drives io request with opcode fetch strobe.
// - opcode fetch plus memory request marks fetch; suppressed when enable bit 0.
// - combined read strobe is memory request and read; idles high in grant.
// - pin-mux bit 3 selects plain memory request; combined read after reset.
// - combined write strobe is memory request and write; same mux bit.
// - wait sampled in second state and wait states; low inserts more.
// - halt or sleep asserts halt status until an interrupt arrives.
// - optional 16-cycle delay of first fetch after halt status rises.
// - bus request beats nmi, honoured at cycle end, bus floats.
// - grant asserted only once address, data and controls are floating.
// - nmi falling edge, top priority interrupt, vector 0066h.
// - primary interrupt level, wired-or with two peripherals, open-drain pin.
// - auxiliary interrupts only when higher ones idle; no fetch or io strobe.
// - auxiliary interrupt edge programmable; levels readable as port c bits.
// - refresh strobe with memory request in plain mode only, refresh address on low 8 lines.
// - transfer-end low during final dma write cycle.
// - dma requests level or edge sensed per programmed mode.
module mpu_external_bus_interface
	import ext_bus_pkg::*;
(
	input  wire logic                  clock_in,
	input  wire logic                  rst_n_in,
	// core side
	input  wire logic                  cyc_start_in,
	input  wire cycle_kind_t           cyc_kind_in,
	input  wire logic                  cyc_write_in,
	input  wire logic [addr_width-1:0] cyc_addr_in,
	input  wire logic [data_width-1:0] cyc_wdata_in,
	input  wire logic                  cyc_dma_last_in,
	input  wire logic                  cyc_dma_chan_in,
	input  wire logic                  halt_enter_in,
	input  wire logic                  timer1_pulse_in,
	input  wire logic [1:0]            periph_irq_in,
	output logic                       cyc_done_out,
	output logic [data_width-1:0]      cyc_rdata_out,
	output logic                       core_stall_out,
	output logic                       nmi_take_out,
	output logic [15:0]                nmi_vector_out,
	output logic                       primary_maskable_interrupt_take_out,
	output logic                       aux_interrupt_one_take_out,
	output logic                       aux_interrupt_two_take_out,
	output logic [1:0]                 dma_request_out,
	// register port
	input  wire logic [7:0]            reg_addr_in,
	input  wire logic [7:0]            reg_wdata_in,
	input  wire logic                  reg_write_in,
	input  wire logic                  reg_read_in,
	output logic [7:0]                 reg_rdata_out,
	// pins
	input  wire logic [addr_width-1:0] address_in,
	output logic [addr_width-1:0]      address_out,
	output logic                       address_oe_out,
	input  wire logic [data_width-1:0] data_in,
	output logic [data_width-1:0]      data_out,
	output logic                       data_oe_out,
	output logic                       read_n_out,
	output logic                       write_n_out,
	output logic                       io_request_strobe_n_out,
	output logic                       opcode_fetch_strobe_n_out,
	output logic                       memory_request_strobe_n_out,
	output logic                       combined_memory_write_strobe_n_out,
	output logic                       control_oe_out,
	output logic                       memory_request_strobe_pin_oe_out,
	output logic                       dram_refresh_strobe_n_out,
	input  wire logic                  wait_n_in,
	output logic                       halt_n_out,
	input  wire logic                  external_master_request_n_in,
	output logic                       external_master_grant_n_out,
	input  wire logic                  nmi_n_in,
	input  wire logic                  primary_maskable_interrupt_n_in,
	output logic                       primary_maskable_interrupt_oe_out,
	input  wire logic                  aux_interrupt_one_n_in,
	input  wire logic                  aux_interrupt_two_n_in,
	output logic                       dma0_transfer_end_n_out,
	output logic                       dma1_transfer_end_n_out,
	input  wire logic                  dma0_request_in_n_in,
	input  wire logic                  dma1_request_in_n_in
);

	// two-flop synchronisers for every pin input except the address and data buses
	localparam int sync_w = 8;
	logic [sync_w-1:0] sync_a;
	logic [sync_w-1:0] sync_b;
	logic [sync_w-1:0] raw_pins;
	assign raw_pins = {dma1_request_in_n_in, dma0_request_in_n_in, aux_interrupt_two_n_in,
		aux_interrupt_one_n_in, primary_maskable_interrupt_n_in, nmi_n_in,
		external_master_request_n_in, wait_n_in};

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			sync_a <= '1;
			sync_b <= '1;
		end else begin
			sync_a <= raw_pins;
			sync_b <= sync_a;
		end
	end

	logic wait_s, external_master_request_s, nmi_s, primary_maskable_interrupt_s, aux_interrupt_one_s, aux_interrupt_two_s, dma0_request_in_s, dma1_request_in_s;
	assign {dma1_request_in_s, dma0_request_in_s, aux_interrupt_two_s, aux_interrupt_one_s, primary_maskable_interrupt_s, nmi_s, external_master_request_s, wait_s} = sync_b;

	logic [sync_w-1:0] prev_s;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			prev_s <= '1;
		else
			prev_s <= sync_b;
	end

	// registers
	logic [7:0] pin_mux;
	logic [7:0] mode_ctl;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pin_mux  <= pin_mux_reset;
			mode_ctl <= mode_ctl_reset;
		end else if (reg_write_in) begin
			if (reg_addr_in == pin_mux_offset)
				pin_mux <= reg_wdata_in;
			if (reg_addr_in == mode_ctl_offset)
				mode_ctl <= reg_wdata_in;
		end
	end

	logic plain_memory_request_strobe;
	assign plain_memory_request_strobe = pin_mux[mux_sel_bit];

	// bus state machine
	bus_state_t  state;
	cycle_kind_t kind;
	logic                  is_write;
	logic [addr_width-1:0] addr;
	logic [data_width-1:0] wdata;
	logic                  dma_last;
	logic                  dma_chan;
	logic                  halted;
	logic [4:0]            exit_cnt;

	logic grant_now;
	assign grant_now = !external_master_request_s;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state <= st_idle;
		end else begin
			case (state)
				st_idle:  if (grant_now)
						state <= st_grant;
					else if (cyc_start_in && !halted && exit_cnt == wait_cnt_reset)
						state <= st_t1;
				st_t1:    state <= st_t2;
				st_t2,
				st_tw:    state <= wait_s ? st_t3 : st_tw;
				st_t3:    state <= grant_now ? st_grant : st_idle;
				st_grant: if (external_master_request_s)
						state <= st_idle;
				default:  state <= st_idle;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			kind     <= cyc_mem;
			is_write <= 1'b0;
			addr     <= '0;
			wdata    <= '0;
			dma_last <= 1'b0;
			dma_chan <= 1'b0;
		end else if (state == st_idle && cyc_start_in) begin
			kind     <= cyc_kind_in;
			is_write <= cyc_write_in;
			dma_last <= cyc_dma_last_in;
			dma_chan <= cyc_dma_chan_in;
			wdata    <= cyc_wdata_in;
			if (cyc_kind_in == cyc_io)
				addr <= {4'h0, cyc_addr_in[io_addr_width-1:0]};
			else if (cyc_kind_in == cyc_dram_refresh_strobe)
				addr <= {12'h000, cyc_addr_in[refresh_width-1:0]};
			else
				addr <= cyc_addr_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			cyc_rdata_out <= '0;
		else if (state == st_t3 && !is_write)
			cyc_rdata_out <= data_in;
	end

	assign cyc_done_out   = (state == st_t3);
	assign core_stall_out = halted || (state == st_grant) || (exit_cnt != wait_cnt_reset);

	// halt and delayed exit
	logic wake;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			halted   <= 1'b0;
			exit_cnt <= wait_cnt_reset;
		end else begin
			if (halt_enter_in && !halted)
				halted <= 1'b1;
			else if (halted && wake) begin
				halted <= 1'b0;
				if (mode_ctl[mode_delay_bit])
					exit_cnt <= 5'(halt_exit_cycles);
			end else if (exit_cnt != wait_cnt_reset)
				exit_cnt <= exit_cnt - 5'h01;
		end
	end
	assign halt_n_out = !halted;

	// interrupts
	logic nmi_pend;
	logic edge1, edge2;
	logic primary_maskable_interrupt_line;
	assign primary_maskable_interrupt_line = !primary_maskable_interrupt_s || (|periph_irq_in);
	assign edge1 = mode_ctl[mode_edge1_bit] ? (aux_interrupt_one_s && !prev_s[4]) : (!aux_interrupt_one_s && prev_s[4]);
	assign edge2 = mode_ctl[mode_edge2_bit] ? (aux_interrupt_two_s && !prev_s[5]) : (!aux_interrupt_two_s && prev_s[5]);
	logic aux_interrupt_one_pend, aux_interrupt_two_pend;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			nmi_pend  <= 1'b0;
			aux_interrupt_one_pend <= 1'b0;
			aux_interrupt_two_pend <= 1'b0;
		end else begin
			if (!nmi_s && prev_s[2])
				nmi_pend <= 1'b1;
			else if (nmi_take_out)
				nmi_pend <= 1'b0;
			if (edge1)
				aux_interrupt_one_pend <= 1'b1;
			else if (aux_interrupt_one_take_out)
				aux_interrupt_one_pend <= 1'b0;
			if (edge2)
				aux_interrupt_two_pend <= 1'b1;
			else if (aux_interrupt_two_take_out)
				aux_interrupt_two_pend <= 1'b0;
		end
	end

	logic boundary;
	assign boundary = (state == st_idle) && !grant_now && exit_cnt == wait_cnt_reset;
	assign wake = nmi_pend || primary_maskable_interrupt_line || aux_interrupt_one_pend || aux_interrupt_two_pend;
	assign nmi_take_out  = boundary && nmi_pend;
	assign primary_maskable_interrupt_take_out = boundary && !nmi_pend && primary_maskable_interrupt_line;
	assign aux_interrupt_one_take_out = boundary && !nmi_pend && !primary_maskable_interrupt_line && aux_interrupt_one_pend;
	assign aux_interrupt_two_take_out = boundary && !nmi_pend && !primary_maskable_interrupt_line && !aux_interrupt_one_pend
		&& aux_interrupt_two_pend;
	assign nmi_vector_out = nmi_vector;
	assign primary_maskable_interrupt_oe_out = |periph_irq_in;

	// dma requests
	logic [1:0] dreq_edge;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			dreq_edge <= 2'h0;
		else begin
			dreq_edge[0] <= (!dma0_request_in_s && prev_s[6]) ||
				(dreq_edge[0] && !(cyc_done_out && !dma_chan));
			dreq_edge[1] <= (!dma1_request_in_s && prev_s[7]) ||
				(dreq_edge[1] && !(cyc_done_out && dma_chan));
		end
	end
	assign dma_request_out[0] = mode_ctl[mode_dma0_request_in_bit] ? dreq_edge[0] : !dma0_request_in_s;
	assign dma_request_out[1] = mode_ctl[mode_dma1_request_in_bit] ? dreq_edge[1] : !dma1_request_in_s;

	// pin drive
	logic active, floating, memory_request_strobe_i, rd_i, wr_i;
	assign active   = (state == st_t1) || (state == st_t2) || (state == st_tw) || (state == st_t3);
	assign floating = (state == st_grant) || halted;
	assign memory_request_strobe_i   = active && (kind == cyc_mem || kind == cyc_fetch || kind == cyc_dram_refresh_strobe);
	assign rd_i     = active && !is_write && kind != cyc_dram_refresh_strobe && kind != cyc_ackx;
	assign wr_i     = active && is_write && (kind == cyc_mem || kind == cyc_io);

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			address_out    <= '0;
			data_out       <= '0;
			address_oe_out <= 1'b0;
			data_oe_out    <= 1'b0;
		end else begin
			address_out <= addr;
			if (!mode_ctl[mode_timer_bit])
				address_out[timer_addr_bit] <= addr[timer_addr_bit];
			else
				address_out[timer_addr_bit] <= timer1_pulse_in;
			data_out       <= wdata;
			address_oe_out <= !floating && state != st_idle;
			data_oe_out    <= !floating && active && is_write;
		end
	end

	assign control_oe_out  = (state != st_grant);
	assign memory_request_strobe_pin_oe_out = (state != st_grant) || !plain_memory_request_strobe;
	assign external_master_grant_n_out = !(state == st_grant && !address_oe_out
		&& !data_oe_out);
	assign read_n_out  = !rd_i;
	assign write_n_out = !wr_i;
	assign io_request_strobe_n_out = !(active && (kind == cyc_io || kind == cyc_ack0));
	assign opcode_fetch_strobe_n_out = !(active && ((kind == cyc_fetch &&
		mode_ctl[mode_oce_bit]) || kind == cyc_ack0));
	assign memory_request_strobe_n_out = plain_memory_request_strobe ? !memory_request_strobe_i : !(memory_request_strobe_i && rd_i);
	assign combined_memory_write_strobe_n_out = !(memory_request_strobe_i && wr_i && !plain_memory_request_strobe);
	assign dram_refresh_strobe_n_out = !(active && kind == cyc_dram_refresh_strobe);
	assign dma0_transfer_end_n_out = !(active && dma_last && is_write && !dma_chan);
	assign dma1_transfer_end_n_out = !(active && dma_last && is_write && dma_chan);

	// register reads, with external-master decode during grant
	logic [7:0] rd_addr;
	assign rd_addr = (state == st_grant) ? address_in[7:0] : reg_addr_in;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			reg_rdata_out <= 8'h00;
		else if (reg_read_in) begin
			case (rd_addr)
				pin_mux_offset:  reg_rdata_out <= pin_mux;
				mode_ctl_offset: reg_rdata_out <= mode_ctl;
				status_offset:   reg_rdata_out <= {3'h0, state == st_grant, nmi_pend,
					aux_interrupt_two_pend, aux_interrupt_one_pend, halted};
				port_c_offset:   reg_rdata_out <= {aux_interrupt_two_s, aux_interrupt_one_s, 6'h00};
				default:         reg_rdata_out <= 8'h00;
			endcase
		end else
			reg_rdata_out <= 8'h00;
	end

endmodule : mpu_external_bus_interface

// ==== tb/mpu_ext_bus_checker_asserts.sv ====
`timescale 1ns/1ps
module mpu_ext_bus_checker
	import ext_bus_pkg::*;
(
	input wire logic       clock_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_write_in,
	input wire logic       external_master_grant_n_out,
	input wire logic       address_oe_out,
	input wire logic       data_oe_out,
	input wire logic       control_oe_out,
	input wire logic       halt_n_out,
	input wire logic       read_n_out,
	input wire logic       write_n_out,
	input wire logic       io_request_strobe_n_out,
	input wire logic       memory_request_strobe_n_out,
	input wire logic       combined_memory_write_strobe_n_out,
	input wire logic       dram_refresh_strobe_n_out,
	input wire logic       cyc_done_out,
	input wire logic       dma0_transfer_end_n_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	logic plain_sel;
	// shadow of the pin-mux select bit
	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			plain_sel <= 1'b0;
		else if (reg_write_in && reg_addr_in == pin_mux_offset)
			plain_sel <= reg_wdata_in[mux_sel_bit];
	end
	AST_GRANT_FLOAT: assert property (!external_master_grant_n_out |->
		!address_oe_out && !data_oe_out && !control_oe_out) else $error("grant on driven bus");
	AST_RESET_FLOAT: assert property ($rose(rst_n_in) |->
		!address_oe_out && !data_oe_out && external_master_grant_n_out) else $error("reset drive");
	AST_HALT_FLOAT: assert property (!halt_n_out [*2] |->
		!address_oe_out && !data_oe_out) else $error("bus driven in halt");
	AST_COMBINED_READ: assert property (!plain_sel && !memory_request_strobe_n_out |->
		!read_n_out && io_request_strobe_n_out) else $error("combined read wrong");
	AST_COMBINED_WRITE: assert property (!plain_sel && !combined_memory_write_strobe_n_out |->
		!write_n_out && io_request_strobe_n_out) else $error("combined write wrong");
	AST_REFRESH: assert property (plain_sel && !dram_refresh_strobe_n_out |->
		!memory_request_strobe_n_out && read_n_out && write_n_out) else $error("refresh wrong");
	AST_DONE_GAP: assert property (cyc_done_out |=> !cyc_done_out [*3])
		else $error("cycle too short");
	AST_TEND_WRITE: assert property (!dma0_transfer_end_n_out |-> !write_n_out && read_n_out)
		else $error("transfer end outside write");
endmodule : mpu_ext_bus_checker
bind mpu_external_bus_interface mpu_ext_bus_checker u_checker (.*);

// ==== tb/ext_bus_partner.sv ====
`timescale 1ns/1ps
module ext_bus_partner
	import ext_bus_pkg::*;
(
	input  wire logic                  clock_in,
	input  wire logic [1:0]            wait_len_in,
	input  wire logic [addr_width-1:0] address_in,
	input  wire logic                  read_n_in,
	input  wire logic                  write_n_in,
	output logic [data_width-1:0]      data_out,
	output logic                       wait_n_out
);
	logic [1:0]            wait_left = 2'h0;
	logic [data_width-1:0] last      = 8'h00;
	// slow part holds wait low ahead of and into its access
	assign wait_n_out = (wait_left == 2'h0);
	// released bus shows the inverse of the last value
	assign data_out = !read_n_in ? (address_in[7:0] ^ address_in[15:8]) : ~last;
	always_ff @(posedge clock_in) begin
		last <= data_out;
		if (read_n_in && write_n_in)
			wait_left <= wait_len_in;
		else if (wait_left != 2'h0)
			wait_left <= wait_left - 2'h1;
	end
endmodule : ext_bus_partner

// ==== tb/mpu_external_bus_interface_bench.sv ====
`timescale 1ns/1ps
module mpu_external_bus_interface_bench
	import ext_bus_pkg::*;
;
	cycle_kind_t cyc_kind_in, kind;
	logic [19:0] cyc_addr_in, address_in, address_out, master_addr;
	logic [7:0]  cyc_wdata_in, cyc_rdata_out, reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [7:0]  data_in, data_out, mem_data;
	logic [15:0] nmi_vector_out;
	logic [1:0]  periph_irq_in, dma_request_out, wait_len;
	logic [6:0]  seen;
	logic clock_in, rst_n_in, cyc_start_in, cyc_write_in, cyc_dma_last_in, cyc_dma_chan_in, wr,
		halt_enter_in, timer1_pulse_in, reg_write_in, reg_read_in, wait_n_in, nmi_n_in,
		external_master_request_n_in, primary_maskable_interrupt_n_in, aux_interrupt_one_n_in,
		aux_interrupt_two_n_in, dma0_request_in_n_in, dma1_request_in_n_in, cyc_done_out,
		core_stall_out, nmi_take_out, primary_maskable_interrupt_take_out, aux_interrupt_one_take_out, aux_interrupt_two_take_out,
		address_oe_out, data_oe_out, read_n_out, write_n_out, io_request_strobe_n_out,
		opcode_fetch_strobe_n_out, memory_request_strobe_n_out, control_oe_out,
		combined_memory_write_strobe_n_out, memory_request_strobe_pin_oe_out, dram_refresh_strobe_n_out,
		halt_n_out, external_master_grant_n_out, primary_maskable_interrupt_oe_out,
		dma0_transfer_end_n_out, dma1_transfer_end_n_out;
	int seed = 32'h45fb;
	int bad_count = 0;
	int total_checks = 0;
	int i, n;
	assign data_in = data_oe_out ? data_out : mem_data;
	assign address_in = address_oe_out ? address_out : master_addr;
	assign primary_maskable_interrupt_n_in = !primary_maskable_interrupt_oe_out;
	mpu_external_bus_interface u_dut (.*);
	ext_bus_partner u_mem (.clock_in(clock_in), .wait_len_in(wait_len), .address_in(address_in),
		.read_n_in(read_n_out), .write_n_in(write_n_out), .data_out(mem_data), .wait_n_out(wait_n_in));
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	task automatic check(input bit ok, input string msg);
		total_checks++;
		if (!ok) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	function automatic logic pick(input int s);
		case (s)
			0: return external_master_grant_n_out;
			1: return nmi_take_out;
			2: return aux_interrupt_one_take_out;
			default: return halt_n_out;
		endcase
	endfunction : pick
	task automatic wait_val(input int s, input logic v);
		for (n = 0; n < 12 && pick(s) !== v; n++) begin
			@(posedge clock_in);
			#1;
		end
		check(pick(s) === v, "event missing");
	endtask : wait_val
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask : reg_wr
	task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1;
		check(reg_rdata_out === e, "register read");
	endtask : reg_chk
	function automatic logic [6:0] exp_seen(cycle_kind_t k, logic w, logic plain, logic oce, logic ch);
		logic m;
		m = (k == cyc_mem);
		return {w && m && !ch, w && m && ch, k == cyc_dram_refresh_strobe, w && m && !plain,
			k == cyc_io || k == cyc_ack0, (k == cyc_fetch && oce) || k == cyc_ack0,
			plain ? (m || k == cyc_fetch || k == cyc_dram_refresh_strobe) : (!w && (m || k == cyc_fetch))};
	endfunction : exp_seen
	task automatic bus_cycle(input cycle_kind_t k, input logic w, input logic ch, input logic [6:0] e);
		logic [19:0] a;
		a = $random(seed);
		seen = 7'h00;
		@(posedge clock_in);
		cyc_start_in <= 1'b1;
		cyc_kind_in <= k;
		cyc_write_in <= w;
		cyc_addr_in <= a;
		cyc_wdata_in <= a[19:12];
		cyc_dma_last_in <= w && k == cyc_mem;
		cyc_dma_chan_in <= ch;
		@(posedge clock_in);
		cyc_start_in <= 1'b0;
		for (n = 0; n < 12; n++) begin
			#1;
			seen |= ~{dma0_transfer_end_n_out, dma1_transfer_end_n_out, dram_refresh_strobe_n_out,
				combined_memory_write_strobe_n_out, io_request_strobe_n_out,
				opcode_fetch_strobe_n_out, memory_request_strobe_n_out};
			if (cyc_done_out === 1'b1)
				break;
			@(posedge clock_in);
		end
		check(n >= 2 + (wait_len != 0) && n <= 4 + wait_len, "cycle length");
		check(seen === e, "strobes");
		@(posedge clock_in);
		#1;
		if (!w && k <= cyc_fetch)
			check(cyc_rdata_out === (a[7:0] ^ a[15:8]), "read data");
	endtask : bus_cycle
	initial begin
		repeat (20000) @(posedge clock_in);
		bad_count++;
		report_and_stop();
	end
	initial begin
		{cyc_start_in, cyc_write_in, cyc_dma_last_in, cyc_dma_chan_in, halt_enter_in} = 5'h00;
		{timer1_pulse_in, reg_write_in, reg_read_in, rst_n_in} = 4'h0;
		{nmi_n_in, external_master_request_n_in, aux_interrupt_one_n_in} = 3'h7;
		{aux_interrupt_two_n_in, dma0_request_in_n_in, dma1_request_in_n_in} = 3'h7;
		cyc_kind_in = cyc_mem;
		{cyc_addr_in, master_addr, cyc_wdata_in, reg_addr_in, reg_wdata_in} = '0;
		{periph_irq_in, wait_len} = 4'h0;
		repeat (10) @(posedge clock_in);
		rst_n_in <= 1'b1;
		reg_chk(pin_mux_offset, pin_mux_reset);
		reg_chk(mode_ctl_offset, mode_ctl_reset);
		reg_chk(8'h3c, 8'h00);
		for (i = 0; i < 36; i++) begin
			if (i == 18) begin
				reg_wr(pin_mux_offset, 8'h08);
				reg_wr(mode_ctl_offset, 8'h00);
			end
			kind = cycle_kind_t'(3'(i % 6));
			wr = kind == cyc_mem ? i[1] : kind == cyc_io ? 1'($random(seed)) : 1'b0;
			wait_len <= kind <= cyc_fetch ? 2'($random(seed)) : 2'h0;
			bus_cycle(kind, wr, i[2], exp_seen(kind, wr, i >= 18, i < 18, i[2]));
		end
		wait_len <= 2'h0;
		reg_wr(pin_mux_offset, pin_mux_reset);
		reg_wr(mode_ctl_offset, mode_ctl_reset);
		@(posedge clock_in);
		master_addr <= $random(seed);
		external_master_request_n_in <= 1'b0;
		wait_val(0, 1'b0);
		check(!address_oe_out && !data_oe_out && !control_oe_out, "bus not floating");
		@(posedge clock_in);
		external_master_request_n_in <= 1'b1;
		wait_val(0, 1'b1);
		@(posedge clock_in);
		halt_enter_in <= 1'b1;
		@(posedge clock_in);
		halt_enter_in <= 1'b0;
		wait_val(3, 1'b0);
		@(posedge clock_in);
		#1;
		check(address_oe_out === 1'b0 && data_oe_out === 1'b0, "halt drive");
		reg_chk(status_offset, 8'h01);
		@(posedge clock_in);
		nmi_n_in <= 1'b0;
		wait_val(1, 1'b1);
		check(nmi_vector_out === nmi_vector, "vector");
		wait_val(3, 1'b1);
		@(posedge clock_in);
		nmi_n_in <= 1'b1;
		aux_interrupt_one_n_in <= 1'b0;
		wait_val(2, 1'b1);
		reg_chk(port_c_offset, 8'h80);
		@(posedge clock_in);
		aux_interrupt_one_n_in <= 1'b1;
		periph_irq_in <= 2'b10;
		@(posedge clock_in);
		#1;
		check(primary_maskable_interrupt_oe_out === 1'b1, "open drain");
		@(posedge clock_in);
		periph_irq_in <= 2'b00;
		dma0_request_in_n_in <= 1'b0;
		timer1_pulse_in <= 1'b1;
		reg_wr(mode_ctl_offset, 8'h43);
		repeat (3) @(posedge clock_in);
		#1;
		check(dma_request_out[0] === 1'b1, "dma level request");
		check(address_out[timer_addr_bit] === 1'b1, "timer on address pin");
		@(posedge clock_in);
		halt_enter_in <= 1'b1;
		@(posedge clock_in);
		halt_enter_in <= 1'b0;
		wait_val(3, 1'b0);
		@(posedge clock_in);
		periph_irq_in <= 2'b01;
		wait_val(3, 1'b1);
		check(core_stall_out === 1'b1, "exit delay start");
		repeat (15) @(posedge clock_in);
		#1;
		check(core_stall_out === 1'b1 && primary_maskable_interrupt_take_out === 1'b0, "exit delay short");
		@(posedge clock_in);
		#1;
		check(core_stall_out === 1'b0 && primary_maskable_interrupt_take_out === 1'b1, "exit delay end");
		@(posedge clock_in);
		periph_irq_in <= 2'b00;
		repeat (4) @(posedge clock_in);
		report_and_stop();
	end
endmodule : mpu_external_bus_interface_bench
